/* logic/dscp_priority_map_upper.sv */
`timescale 1ns/1ps

// bank layout, field index = code - 0x34:
//   byte 0 (0x9d): fields 3..0, codes 0x37..0x34
//   byte 1 (0x9e): fields 7..4, codes 0x3b..0x38
//   byte 2 (0x9f): fields 11..8, codes 0x3f..0x3c
// within a byte the lowest code sits in bits 1-0

// timing of the two interfaces:
//   register read: answer with read echo exactly one cycle after the request
//   register write: no answer, new value visible to the next cycle's access
//   lookup: answer exactly one cycle after the request, one per cycle allowed

// hazards a user must know:
//   a read and a write to the same byte in one cycle return the old value
//   writes to unmapped addresses are dropped without any indication
//   codes below 0x34 report no hit here; the lower bank answers for them

module dscp_priority_map_upper
    import diffserv_map_pkg::*;
#(
    // number of mapping bytes served by this bank
    parameter int num_bytes = 3
) (
    // core clock and synchronous reset
    input wire logic clk,
    input wire logic sys_rst,

    // management register access
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_hit,

    // classifier lookup
    input wire lookup_req_t lookup_req,
    output lookup_rsp_t lookup_rsp
);

    // field count and width of the field index
    localparam int num_fields = num_bytes * fields_per_byte;
    localparam int field_idx_width = 4;

    // the address decode and the code window below serve exactly three bytes
    if (num_bytes != 3) begin : g_bad_count
        $error("dscp_priority_map_upper serves exactly three mapping bytes");
    end

    // the field index must reach every field of the bank
    if (num_fields > (1 << field_idx_width)) begin : g_bad_index
        $error("dscp_priority_map_upper field index too narrow");
    end

    // storage: one byte per mapping register
    logic [7:0] map_byte [num_bytes];

    // storage viewed as one 2-bit priority per code
    logic [1:0] field_val [num_fields];

    // management decode
    logic [1:0] sel_idx;
    logic sel_ok;
    logic rd_take;
    logic [num_bytes-1:0] byte_wr;
    logic [7:0] next_rdata;

    // lookup decode
    logic [5:0] code;
    logic [5:0] code_off;
    logic in_bank;
    logic [field_idx_width-1:0] field_idx;
    logic [1:0] sel_field;
    logic lookup_hit;
    lookup_rsp_t next_rsp;

    // address decode for the management access; unmapped addresses are refused
    always_comb begin
        sel_ok = 1'b1;
        if (reg_req.addr == map_13_addr) begin
            sel_idx = 2'd0;
        end else if (reg_req.addr == map_14_addr) begin
            sel_idx = 2'd1;
        end else if (reg_req.addr == map_15_addr) begin
            sel_idx = 2'd2;
        end else begin
            sel_idx = 2'd0;
            sel_ok = 1'b0;
        end
    end

    // a read is served only at one of the three mapped addresses
    assign rd_take = reg_req.rd_en && sel_ok;

    // per-byte write strobe; a write to an unmapped address touches nothing
    for (genvar i = 0; i < num_bytes; i++) begin : g_wr
        assign byte_wr[i] = reg_req.wr_en && sel_ok && (sel_idx == 2'(i));
    end

    // mapping bytes, cleared so that every code starts at the lowest priority
    for (genvar i = 0; i < num_bytes; i++) begin : g_byte
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                map_byte[i] <= map_reset;
            end else if (byte_wr[i]) begin
                map_byte[i] <= reg_req.wdata;
            end
        end
    end

    // unpack each byte into its four fields, lowest code in bits 1-0
    for (genvar f = 0; f < num_fields; f++) begin : g_field
        localparam int byte_pos = f / fields_per_byte;
        localparam int bit_pos = (f % fields_per_byte) * field_width;
        assign field_val[f] = map_byte[byte_pos][bit_pos +: field_width];
    end

    // read echo: one cycle after every read request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd_en;
        end
    end

    // hit flag: raised with the echo when the read address was mapped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_hit <= 1'b0;
        end else begin
            reg_hit <= rd_take;
        end
    end

    // next read data: mapped byte, 00 for an unmapped read, otherwise held
    always_comb begin
        next_rdata = reg_rdata;
        if (rd_take) begin
            next_rdata = map_byte[sel_idx];
        end else if (reg_req.rd_en) begin
            next_rdata = 8'h00;
        end
    end

    // read data register, held until the next read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= map_reset;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // six-bit code from the upper tos bits
    assign code = lookup_req.tos[code_msb:code_lsb];

    // offset into this bank; wraps for codes of the lower bank
    assign code_off = code - first_code;

    // codes 0x34 up to 0x3f belong to this bank
    assign in_bank = (code >= first_code);

    // field index held at zero outside the bank so the array is never overrun
    always_comb begin
        if (in_bank) begin
            field_idx = code_off[field_idx_width-1:0];
        end else begin
            field_idx = '0;
        end
    end

    // selected priority field
    assign sel_field = field_val[field_idx];

    // only ip frames with a code in this bank take a priority from the map
    assign lookup_hit = lookup_req.valid && lookup_req.is_ip && in_bank;

    // next lookup answer; everything but a hit reports priority 00
    always_comb begin
        next_rsp = '0;
        next_rsp.valid = lookup_req.valid;
        if (lookup_hit) begin
            next_rsp.hit = 1'b1;
            next_rsp.prio = sel_field;
        end else begin
            next_rsp.hit = 1'b0;
            next_rsp.prio = 2'b00;
        end
    end

    // lookup answer register, one cycle after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lookup_rsp <= '0;
        end else begin
            lookup_rsp <= next_rsp;
        end
    end

endmodule : dscp_priority_map_upper

/* include/diffserv_map_pkg.sv */
package diffserv_map_pkg;

    // register addresses of the three upper mapping bytes
    localparam logic [7:0] map_13_addr = 8'h9d;
    localparam logic [7:0] map_14_addr = 8'h9e;
    localparam logic [7:0] map_15_addr = 8'h9f;

    // value after reset of every mapping byte
    localparam logic [7:0] map_reset = 8'h00;

    // first code covered by this bank and field geometry
    localparam logic [5:0] first_code = 6'h34;
    localparam int field_width = 2;
    localparam int fields_per_byte = 4;
    localparam int code_msb = 7;
    localparam int code_lsb = 2;

    // register access request from the management interface
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // one classification lookup from the frame parser
    typedef struct packed {
        logic valid;
        logic is_ip;
        logic [7:0] tos;
    } lookup_req_t;

    // lookup answer toward the priority resolver
    typedef struct packed {
        logic valid;
        logic hit;
        logic [1:0] prio;
    } lookup_rsp_t;

endpackage : diffserv_map_pkg

/* verif/map_chk.sv */
`timescale 1ns/1ps
module map_chk import diffserv_map_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_hit,
    input wire lookup_req_t lookup_req,
    input wire lookup_rsp_t lookup_rsp);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire hit = reg_req.addr inside {map_13_addr, map_14_addr, map_15_addr};
    property p_rd; reg_req.rd_en |=> reg_rvalid && reg_hit == $past(hit); endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_lk; lookup_req.valid |=> lookup_rsp.valid; endproperty
    a_lk: assert property (p_lk) else $error("no lookup");
    property p_ip; lookup_req.valid && !lookup_req.is_ip |=> lookup_rsp == 4'h8; endproperty
    a_ip: assert property (p_ip) else $error("non ip hit");
    wire in_bank = lookup_req.tos[7:2] >= first_code;
    property p_rd_idle; !reg_req.rd_en |=> !reg_rvalid && !reg_hit; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read echo without request");
    property p_rd_miss; reg_req.rd_en && !hit |=> reg_rdata == 8'h00; endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");
    property p_lk_idle; !lookup_req.valid |=> !lookup_rsp.valid && !lookup_rsp.hit; endproperty
    a_lk_idle: assert property (p_lk_idle) else $error("answer without lookup");
    property p_lk_hit; lookup_req.valid && lookup_req.is_ip && in_bank |=> lookup_rsp.hit;
    endproperty
    a_lk_hit: assert property (p_lk_hit) else $error("ip lookup missed");
    property p_lk_low; lookup_req.valid && !in_bank |=> lookup_rsp == 4'h8; endproperty
    a_lk_low: assert property (p_lk_low) else $error("lower code hit");
endmodule : map_chk
bind dscp_priority_map_upper map_chk chk (.*);

/* verif/tb_dscp_priority_map_upper.sv */
`timescale 1ns/1ps
`define CHK(e, s) check_count++; if (s !== e) begin failures++; \
    $display("CHECK FAILED answer expected %h seen %h", e, s); end
module tb_dscp_priority_map_upper;
    import diffserv_map_pkg::*;
    logic clk = 0, sys_rst = 1, reg_rvalid, reg_hit;
    logic [7:0] reg_rdata, m [3];
    logic [8:0] q [$], e;
    reg_req_t reg_req = 0;
    lookup_req_t lookup_req = 0;
    lookup_rsp_t lookup_rsp;
    int failures = 0, check_count = 0;
    wire [8:0] s = reg_rvalid ? {reg_hit, reg_rdata} : {5'h0, lookup_rsp};
    dscp_priority_map_upper dut (.*);
    initial forever #4 clk = ~clk;
    task op(logic [3:0] f, logic [7:0] a, d, logic [8:0] x);
        reg_req <= {f[3:2], a, d};
        lookup_req <= {f[1:0], a};
        if (f[2:1]) q.push_back(x);
        @(posedge clk);
    endtask : op
    always @(posedge clk) if ((reg_rvalid | lookup_rsp.valid) === 1'b1) begin
        e = q.pop_front();
        `CHK(e, s)
    end
    initial begin
        void'($urandom(83723));
        repeat (10) @(posedge clk);
        sys_rst <= 0;
        op(3, 8'hcc, 0, 9'h8);
        op(2, 8'hfc, 0, 9'h8);
        for (int i = 0; i < 3; i++) begin
            m[i] = 8'($urandom);
            op(4, 8'(8'h9d + i), 0, 9'h100);
            op(8, 8'(8'h9d + i), m[i], 0);
            op(4, 8'(8'h9d + i), 0, {1'b1, m[i]});
            for (int k = 0; k < 4; k++) op(3, {6'(52 + 4 * i + k), 2'($urandom)}, 0,
                {7'h3, m[i][2 * k +: 2]});
        end
        op(2, 8'hff, 0, 9'h8);
        op(12, 8'h9d, ~m[0], {1'b1, m[0]});
        op(4, 8'h9d, 0, {1'b1, ~m[0]});
        op(8, 8'h90, 8'hff, 0);
        op(4, 8'h90, 0, 9'h0);
        repeat (3) op(0, 0, 0, 0);
        $display("map test done");
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        op(4, 8'h9f, 0, 9'h100);
        op(3, 8'hfc, 0, 9'hc);
        repeat (3) op(0, 0, 0, 0);
        $display("reset test done");
        if (q.size() != 0) failures++;
        results();
    end
    initial begin
        #5000 failures++;
        results();
    end
    task results;
        $display("%0d checks %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
endmodule : tb_dscp_priority_map_upper
